/* verilog/ptbc_pkg.sv */
// Constants, field layout and state encoding for the target base address block.
// Assumes one 40 MHz clock (MCLK) and the PCI reset as the block reset.
//
// Operation
// - Image 0 on: strap high, EEPROM bit set
// - Disable option strap enables both images
// - Disabled image register reads zero, read-only
// - Image 1 on: strap high, EEPROM bit set
// - Address phase compares upper lines against base
// - Block size code sets compared line count
// - Only size-selected base bits writable, rest zero
// - Prefetch needs flag and separate enable bit
// - Prefetch and space flags read as encoded
// - Base fields clear on reset
// - Subsystem identifiers from EEPROM, else zero
// - Identifier written only locally, not while loading
// - ROM register on: EEPROM bit and strap
// - ROM writable both buses, decode needs enable
// - ROM writable bits follow 3-bit size code
// - Messaging unit moves image 0 to 0x010
package ptbc_pkg;

    // ------------------------------------------------------------
    // Configuration offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IMG0 = 8'h18;
    localparam logic [7:0] OFS_IMG0_ALT = 8'h10;
    localparam logic [7:0] OFS_IMG1 = 8'h1c;
    localparam logic [7:0] OFS_SID = 8'h2c;
    localparam logic [7:0] OFS_ROM = 8'h30;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PREFETCHABLE_FLAG_BIT = 3;
    localparam int PAS_BIT = 0;
    localparam int ROM_EN_BIT = 0;
    localparam logic [15:0] RST_BA = 16'h0000;
    localparam logic [31:0] RST_SID = 32'h0000_0000;
    localparam logic [15:0] FULL_MASK = 16'hffff;

    // ------------------------------------------------------------
    // EEPROM byte map
    // ------------------------------------------------------------
    localparam logic [3:0] EE_BYTE_SUBSYSTEM_VENDOR_IDENT_LO = 4'h1;
    localparam logic [3:0] EE_BYTE_SUBSYSTEM_VENDOR_IDENT_HI = 4'h2;
    localparam logic [3:0] EE_BYTE_SID_LO = 4'h3;
    localparam logic [3:0] EE_BYTE_SID_HI = 4'h4;
    localparam logic [3:0] EE_BYTE_ROM = 4'h5;
    localparam logic [3:0] EE_BYTE_IMG0 = 4'h7;
    localparam logic [3:0] EE_BYTE_IMG1 = 4'h8;
    localparam int EE_BIT_ROM_EN = 7;
    localparam int EE_BIT_IMG0_EN = 5;
    localparam int EE_BIT_IMG0_PREFETCHABLE_FLAG = 6;
    localparam int EE_BIT_IMG0_PAS = 4;
    localparam int EE_BIT_IMG1_EN = 7;
    localparam int EE_BIT_IMG1_PREFETCHABLE_FLAG = 6;
    localparam int EE_BIT_IMG1_PAS = 5;

    // ------------------------------------------------------------
    // Timing and states
    // ------------------------------------------------------------
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    typedef enum logic [1:0] {
        PTBC_STRAP = 2'b00,
        PTBC_LOAD = 2'b01,
        PTBC_RUN = 2'b10
    } ptbc_state_type;

endpackage : ptbc_pkg

/* verilog/ptbc_bar_config.sv */
// Target image, subsystem identification and expansion ROM base registers.
// Assumes config and local accesses are one-cycle strobes on MCLK and the
// EEPROM reader hands over bytes with an index while the load request stands.
`timescale 1ns/1ps

module ptbc_bar_config
    import ptbc_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic EEPROM_ENABLE_PIN,
    input wire logic PCI_DISABLE_OPTION,
    input wire logic MESSAGING_UNIT_ENABLE,
    input wire logic [3:0] IMG0_BLOCK_SIZE_CODE,
    input wire logic [3:0] IMG1_BLOCK_SIZE_CODE,
    input wire logic [2:0] ROM_BLOCK_SIZE_CODE,
    input wire logic IMG0_LOCAL_PREFETCH_ENABLE,
    input wire logic IMG1_LOCAL_PREFETCH_ENABLE,
    input wire logic EE_BYTE_VALID,
    input wire logic [3:0] EE_BYTE_INDEX,
    input wire logic [7:0] EE_BYTE_DATA,
    input wire logic EE_LOAD_DONE,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    input wire logic LCL_WR,
    input wire logic LCL_RD,
    input wire logic [7:0] LCL_ADDR,
    input wire logic [3:0] LCL_BE,
    input wire logic [31:0] LCL_WDATA,
    input wire logic ADDR_PHASE,
    input wire logic [31:0] AD,
    input wire logic ADDR_IS_IO,
    output logic EE_LOAD_REQ,
    output logic [31:0] CFG_RDATA,
    output logic CFG_RVALID,
    output logic [31:0] LCL_RDATA,
    output logic LCL_RVALID,
    output logic IMG0_HIT,
    output logic IMG1_HIT,
    output logic ROM_HIT,
    output logic IMG0_PREFETCH_ACTIVE,
    output logic IMG1_PREFETCH_ACTIVE
);

    // ------------------------------------------------------------
    // Strap synchronisers and latching
    // ------------------------------------------------------------
    logic ee_s1_r, ee_s2_r, ee_s3_r;
    logic dis_s1_r, dis_s2_r, dis_s3_r;
    logic ee_pin_r, pci_disable_option_r;
    logic [2:0] settle_r;
    ptbc_state_type state_r;
    logic loading_r;

    // Pins are asynchronous; third stage lets us see a settled level
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ee_s1_r <= 1'b0;
            ee_s2_r <= 1'b0;
            ee_s3_r <= 1'b0;
            dis_s1_r <= 1'b0;
            dis_s2_r <= 1'b0;
            dis_s3_r <= 1'b0;
        end
        else
        begin
            ee_s1_r <= EEPROM_ENABLE_PIN;
            ee_s2_r <= ee_s1_r;
            ee_s3_r <= ee_s2_r;
            dis_s1_r <= PCI_DISABLE_OPTION;
            dis_s2_r <= dis_s1_r;
            dis_s3_r <= dis_s2_r;
        end
    end

    // Straps count only once both late stages agree
    wire straps_steady = (ee_s2_r == ee_s3_r) && (dis_s2_r == dis_s3_r);
    wire settle_done = (settle_r == STRAP_SETTLE);
    wire strap_take = (state_r == PTBC_STRAP) && settle_done && straps_steady;

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    // Straps caught just after reset release, then EEPROM load if strapped
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_r <= PTBC_STRAP;
            settle_r <= 3'h0;
            ee_pin_r <= 1'b0;
            pci_disable_option_r <= 1'b0;
            loading_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                PTBC_STRAP:
                begin
                    if (!settle_done)
                        settle_r <= settle_r + 3'h1;
                    if (strap_take)
                    begin
                        ee_pin_r <= ee_s3_r;
                        pci_disable_option_r <= dis_s3_r;
                        loading_r <= ee_s3_r;
                        state_r <= ee_s3_r ? PTBC_LOAD : PTBC_RUN;
                    end
                end
                PTBC_LOAD:
                begin
                    if (EE_LOAD_DONE)
                    begin
                        loading_r <= 1'b0;
                        state_r <= PTBC_RUN;
                    end
                end
                PTBC_RUN:
                begin
                    loading_r <= 1'b0;
                end
                default:
                begin
                    state_r <= PTBC_STRAP;
                    loading_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic ee_img0_en_r, ee_img1_en_r, ee_rom_en_r;
    logic [15:0] ba0_r, ba1_r, rom_ba_r;
    logic pref0_r, pref1_r, pas0_r, pas1_r, rom_dec_r;
    logic [31:0] sid_r;

    // Enables from straps and EEPROM bits
    wire img0_on = (ee_pin_r && ee_img0_en_r) || pci_disable_option_r;
    wire img1_on = (ee_pin_r && ee_img1_en_r) || pci_disable_option_r;
    wire rom_on = ee_pin_r && ee_rom_en_r;

    // Size-selected masks: writable bits and compared lines are the same set
    wire [15:0] mask0 = FULL_MASK << IMG0_BLOCK_SIZE_CODE;
    wire [15:0] mask1 = FULL_MASK << IMG1_BLOCK_SIZE_CODE;
    wire [15:0] rmask = FULL_MASK << ROM_BLOCK_SIZE_CODE;
    wire [7:0] img0_ofs = MESSAGING_UNIT_ENABLE ? OFS_IMG0_ALT : OFS_IMG0;

    // Read images; disabled registers read all zeros
    wire [31:0] rd_img0 = img0_on ? {ba0_r & mask0, 12'h000, pref0_r, 2'b00, pas0_r}
                                  : 32'h0000_0000;
    wire [31:0] rd_img1 = img1_on ? {ba1_r & mask1, 12'h000, pref1_r, 2'b00, pas1_r}
                                  : 32'h0000_0000;
    wire [31:0] rd_rom = rom_on ? {rom_ba_r & rmask, 15'h0000, rom_dec_r}
                                : 32'h0000_0000;

    // Shared read decode; unmapped offsets read zero
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == img0_ofs)
            v = rd_img0;
        else if (a == OFS_IMG1)
            v = rd_img1;
        else if (a == OFS_SID)
            v = sid_r;
        else if (a == OFS_ROM)
            v = rd_rom;
        return v;
    endfunction : rd_word

    // ------------------------------------------------------------
    // Write selection
    // ------------------------------------------------------------
    // Local write wins a same-cycle collision; writes wait until loading ends
    wire w_lcl = LCL_WR;
    wire w_go = (LCL_WR || CFG_WR) && (state_r == PTBC_RUN) && !loading_r;
    wire [7:0] w_addr = w_lcl ? LCL_ADDR : CFG_ADDR;
    wire [3:0] w_be = w_lcl ? LCL_BE : CFG_BE;
    wire [31:0] w_data = w_lcl ? LCL_WDATA : CFG_WDATA;
    wire [31:0] w_bemask = {{8{w_be[3]}}, {8{w_be[2]}}, {8{w_be[1]}}, {8{w_be[0]}}};
    wire w_img0 = w_go && (w_addr == img0_ofs) && img0_on;
    wire w_img1 = w_go && (w_addr == OFS_IMG1) && img1_on;
    wire w_sid = w_go && w_lcl && (w_addr == OFS_SID);
    wire w_rom = w_go && (w_addr == OFS_ROM) && rom_on;
    wire [15:0] w_hi = w_data[31:16];
    wire [15:0] w_hi_mask = w_bemask[31:16];

    // Byte-lane merges; bits outside the size mask are dropped
    wire [15:0] ba0_nxt = ((ba0_r & ~w_hi_mask) | (w_hi & w_hi_mask)) & mask0;
    wire [15:0] ba1_nxt = ((ba1_r & ~w_hi_mask) | (w_hi & w_hi_mask)) & mask1;
    wire [15:0] rom_ba_nxt = ((rom_ba_r & ~w_hi_mask) | (w_hi & w_hi_mask)) & rmask;
    wire [31:0] sid_nxt = (sid_r & ~w_bemask) | (w_data & w_bemask);

    // EEPROM byte capture strobes
    wire ee_take = EE_BYTE_VALID && loading_r;
    wire ee_img0 = ee_take && (EE_BYTE_INDEX == EE_BYTE_IMG0);
    wire ee_img1 = ee_take && (EE_BYTE_INDEX == EE_BYTE_IMG1);

    // ------------------------------------------------------------
    // Target image registers
    // ------------------------------------------------------------
    // Base fields clear on reset; flags from EEPROM, prefetch flag also from local writes
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ba0_r <= RST_BA;
            ba1_r <= RST_BA;
            pref0_r <= 1'b0;
            pref1_r <= 1'b0;
            pas0_r <= 1'b0;
            pas1_r <= 1'b0;
            ee_img0_en_r <= 1'b0;
            ee_img1_en_r <= 1'b0;
        end
        else
        begin
            if (w_img0)
                ba0_r <= ba0_nxt;
            if (w_img1)
                ba1_r <= ba1_nxt;
            if (w_img0 && w_lcl && w_be[0])
                pref0_r <= w_data[PREFETCHABLE_FLAG_BIT];
            if (w_img1 && w_lcl && w_be[0])
                pref1_r <= w_data[PREFETCHABLE_FLAG_BIT];
            if (ee_img0)
            begin
                ee_img0_en_r <= EE_BYTE_DATA[EE_BIT_IMG0_EN];
                pref0_r <= EE_BYTE_DATA[EE_BIT_IMG0_PREFETCHABLE_FLAG];
                pas0_r <= EE_BYTE_DATA[EE_BIT_IMG0_PAS];
            end
            if (ee_img1)
            begin
                ee_img1_en_r <= EE_BYTE_DATA[EE_BIT_IMG1_EN];
                pref1_r <= EE_BYTE_DATA[EE_BIT_IMG1_PREFETCHABLE_FLAG];
                pas1_r <= EE_BYTE_DATA[EE_BIT_IMG1_PAS];
            end
        end
    end

    // ------------------------------------------------------------
    // Subsystem identification and expansion ROM
    // ------------------------------------------------------------
    // Identifier stays zero unless loaded; only the local bus may write it
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            sid_r <= RST_SID;
            rom_ba_r <= RST_BA;
            rom_dec_r <= 1'b0;
            ee_rom_en_r <= 1'b0;
        end
        else
        begin
            if (w_sid)
                sid_r <= sid_nxt;
            if (w_rom)
                rom_ba_r <= rom_ba_nxt;
            if (w_rom && w_be[0])
                rom_dec_r <= w_data[ROM_EN_BIT];
            if (ee_take)
            begin
                case (EE_BYTE_INDEX)
                    EE_BYTE_SUBSYSTEM_VENDOR_IDENT_LO: sid_r[7:0] <= EE_BYTE_DATA;
                    EE_BYTE_SUBSYSTEM_VENDOR_IDENT_HI: sid_r[15:8] <= EE_BYTE_DATA;
                    EE_BYTE_SID_LO: sid_r[23:16] <= EE_BYTE_DATA;
                    EE_BYTE_SID_HI: sid_r[31:24] <= EE_BYTE_DATA;
                    EE_BYTE_ROM: ee_rom_en_r <= EE_BYTE_DATA[EE_BIT_ROM_EN];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Transaction decode
    // ------------------------------------------------------------
    // Compare only the lines the size code keeps; space type must match
    wire hit0 = ADDR_PHASE && img0_on && (ADDR_IS_IO == pas0_r)
                && (((AD[31:16] ^ ba0_r) & mask0) == 16'h0000);
    wire hit1 = ADDR_PHASE && img1_on && (ADDR_IS_IO == pas1_r)
                && (((AD[31:16] ^ ba1_r) & mask1) == 16'h0000);
    wire hitr = ADDR_PHASE && rom_on && rom_dec_r && !ADDR_IS_IO
                && (((AD[31:16] ^ rom_ba_r) & rmask) == 16'h0000);

    // Registered outputs: hits, prefetch and read data one cycle later
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            IMG0_HIT <= 1'b0;
            IMG1_HIT <= 1'b0;
            ROM_HIT <= 1'b0;
            IMG0_PREFETCH_ACTIVE <= 1'b0;
            IMG1_PREFETCH_ACTIVE <= 1'b0;
            CFG_RDATA <= 32'h0000_0000;
            CFG_RVALID <= 1'b0;
            LCL_RDATA <= 32'h0000_0000;
            LCL_RVALID <= 1'b0;
        end
        else
        begin
            IMG0_HIT <= hit0;
            IMG1_HIT <= hit1;
            ROM_HIT <= hitr;
            IMG0_PREFETCH_ACTIVE <= pref0_r && IMG0_LOCAL_PREFETCH_ENABLE;
            IMG1_PREFETCH_ACTIVE <= pref1_r && IMG1_LOCAL_PREFETCH_ENABLE;
            CFG_RDATA <= CFG_RD ? rd_word(CFG_ADDR) : CFG_RDATA;
            CFG_RVALID <= CFG_RD;
            LCL_RDATA <= LCL_RD ? rd_word(LCL_ADDR) : LCL_RDATA;
            LCL_RVALID <= LCL_RD;
        end
    end

    // Load request is the loading flag itself
    assign EE_LOAD_REQ = loading_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    AST_NO_STRAP_OFF: assert property (
        (!ee_pin_r && !pci_disable_option_r) |-> (!img0_on && !img1_on && !rom_on))
        else $error("image enabled without strap");

    AST_DIS_ON: assert property (
        pci_disable_option_r |-> (img0_on && img1_on))
        else $error("disable option did not enable images");

    AST_OFF_READ_ZERO: assert property (
        (CFG_RD && CFG_ADDR == OFS_IMG1 && !img1_on) |=> (CFG_RDATA == 32'h0000_0000))
        else $error("disabled image read not zero");

    AST_IMG1_EN_SRC: assert property (
        (img1_on && !pci_disable_option_r) |-> (ee_pin_r && ee_img1_en_r))
        else $error("image 1 enabled without EEPROM bit");

    AST_HIT_MATCH: assert property (
        IMG1_HIT |-> ($past(ADDR_PHASE)
            && ((($past(AD[31:16]) ^ $past(ba1_r)) & $past(mask1)) == 16'h0000)))
        else $error("image 1 hit without address match");

    AST_FULL_SIZE: assert property (
        (ADDR_PHASE && img1_on && IMG1_BLOCK_SIZE_CODE == 4'hf
            && AD[31] == ba1_r[15] && ADDR_IS_IO == pas1_r) |=> IMG1_HIT)
        else $error("2 Gbyte image missed on top line");

    AST_BA_MASK: assert property (
        (CFG_RD && CFG_ADDR == OFS_IMG1)
            |=> (((CFG_RDATA[31:16] & ~$past(mask1)) == 16'h0000) && CFG_RDATA[15:4] == 12'h000))
        else $error("unwritable base bits read nonzero");

    AST_PREFETCHABLE_FLAG_GATE: assert property (
        IMG0_PREFETCH_ACTIVE |-> $past(pref0_r && IMG0_LOCAL_PREFETCH_ENABLE))
        else $error("prefetch without both controls");

    AST_SPACE_CLAIM: assert property (
        IMG0_HIT |-> ($past(ADDR_IS_IO) == $past(pas0_r)))
        else $error("hit on wrong address space");

    AST_BA_RESET: assert property (
        (state_r == PTBC_STRAP) |-> (ba0_r == RST_BA && ba1_r == RST_BA))
        else $error("base field not clear after reset");

    AST_SID_ZERO: assert property (
        ($past(state_r) == PTBC_STRAP && state_r == PTBC_RUN) |-> (sid_r == RST_SID))
        else $error("identifier nonzero without load");

    AST_SID_PCI: assert property (
        (CFG_WR && !LCL_WR && !EE_BYTE_VALID) |=> $stable(sid_r))
        else $error("PCI write changed identifier");

    AST_ROM_OFF: assert property (
        (LCL_RD && LCL_ADDR == OFS_ROM && !rom_on) |=> (LCL_RDATA == 32'h0000_0000))
        else $error("disabled ROM register read not zero");

    AST_ROM_LOAD_BLOCK: assert property (
        (loading_r && (CFG_WR || LCL_WR)) |=> ($stable(rom_ba_r) && $stable(rom_dec_r)))
        else $error("ROM register written during load");

    AST_ROM_DECODE: assert property (
        ROM_HIT |-> $past(rom_dec_r && rom_on))
        else $error("ROM hit without decode enable");

    AST_ROM_MASK: assert property (
        (LCL_RD && LCL_ADDR == OFS_ROM) |=> ((LCL_RDATA[31:16] & ~$past(rmask)) == 16'h0000))
        else $error("ROM unwritable bits nonzero");

    AST_RELOC: assert property (
        (CFG_RD && MESSAGING_UNIT_ENABLE && CFG_ADDR == OFS_IMG0) |=> (CFG_RDATA == 32'h0))
        else $error("image 0 still at old offset");

    AST_CLAIM_EN: assert property (
        (IMG0_HIT || IMG1_HIT) |-> ($past(img0_on) || $past(img1_on)))
        else $error("claim on disabled image");

    // Main scenarios
    COV_LOAD_DONE: cover property (loading_r ##1 !loading_r);
    COV_IMG0_HIT: cover property (IMG0_HIT);
    COV_ROM_HIT: cover property (ROM_HIT);
    COV_SIZING: cover property (CFG_WR && CFG_ADDR == OFS_IMG1 && img1_on ##1 CFG_RD);

endmodule : ptbc_bar_config

/* tb/ptbc_ee_model.sv */
// EEPROM byte source: answers the load request with bytes 1 to 8, then done.
// Assumes the bench sets the byte values before the reset that starts a load.
`timescale 1ns/1ps

module ptbc_ee_model
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic EE_LOAD_REQ,
    input wire logic SLOW,
    input wire logic [7:0] ROM_BYTE,
    input wire logic [7:0] IMG0_BYTE,
    input wire logic [7:0] IMG1_BYTE,
    input wire logic [31:0] SID_WORD,
    output logic EE_BYTE_VALID,
    output logic [3:0] EE_BYTE_INDEX,
    output logic [7:0] EE_BYTE_DATA,
    output logic EE_LOAD_DONE
);
    logic [3:0] step_r;
    logic tick_r;
    wire logic go = EE_LOAD_REQ && tick_r && step_r < 4'ha;

    // Byte map; index 6 carries nothing
    function automatic logic [7:0] pick(input logic [3:0] i);
        case (i)
            4'h1, 4'h2, 4'h3, 4'h4: return SID_WORD[8*(i-1) +: 8];
            4'h5: return ROM_BYTE;
            4'h7: return IMG0_BYTE;
            4'h8: return IMG1_BYTE;
            default: return 8'h00;
        endcase
    endfunction : pick

    // Idle lines toggle so stale data is never mistaken for a byte
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            step_r <= 4'h1;
            tick_r <= 1'b0;
            {EE_BYTE_VALID, EE_LOAD_DONE, EE_BYTE_INDEX, EE_BYTE_DATA} <= '0;
        end
        else
        begin
            tick_r <= SLOW ? !tick_r : 1'b1; // Slow reader: one byte in two cycles
            step_r <= go ? step_r + 4'h1 : step_r;
            EE_BYTE_VALID <= go && step_r < 4'h9;
            EE_LOAD_DONE <= go && step_r == 4'h9;
            EE_BYTE_INDEX <= go ? step_r : ~EE_BYTE_INDEX;
            EE_BYTE_DATA <= go ? pick(step_r) : ~EE_BYTE_DATA;
        end
    end
endmodule : ptbc_ee_model

/* tb/tb_pci_target_bar_config.sv */
// Bench for the target base address block with an EEPROM byte source.
// Assumes the design package and the EEPROM model are compiled first.
`timescale 1ns/1ps

module tb_pci_target_bar_config
    import ptbc_pkg::*;
;
    logic MCLK = '0, ARST_N = '0, EEPROM_ENABLE_PIN = '0, PCI_DISABLE_OPTION = '0;
    logic MESSAGING_UNIT_ENABLE = '0, IMG0_LOCAL_PREFETCH_ENABLE = '0;
    logic IMG1_LOCAL_PREFETCH_ENABLE = '0, ADDR_PHASE = '0, ADDR_IS_IO = '0;
    logic CFG_WR = '0, CFG_RD = '0, LCL_WR = '0, LCL_RD = '0, slow = '0;
    logic [3:0] IMG0_BLOCK_SIZE_CODE = '0, IMG1_BLOCK_SIZE_CODE = '0;
    logic [3:0] CFG_BE = 4'hf, LCL_BE = 4'hf, EE_BYTE_INDEX;
    logic [2:0] ROM_BLOCK_SIZE_CODE = '0;
    logic [7:0] CFG_ADDR = '0, LCL_ADDR = '0, b5 = '0, b7 = '0, b8 = '0, EE_BYTE_DATA;
    logic [31:0] CFG_WDATA = '0, LCL_WDATA = '0, AD = '0, subsystem_ident = '0, CFG_RDATA, LCL_RDATA;
    logic EE_BYTE_VALID, EE_LOAD_DONE, EE_LOAD_REQ, CFG_RVALID, LCL_RVALID;
    logic IMG0_HIT, IMG1_HIT, ROM_HIT, IMG0_PREFETCH_ACTIVE, IMG1_PREFETCH_ACTIVE;
    int bad_count = 0, num_checks = 0, cyc = 0;

    ptbc_bar_config dut_u (.*);
    ptbc_ee_model ee_u (.*, .SLOW(slow), .ROM_BYTE(b5), .IMG0_BYTE(b7), .IMG1_BYTE(b8),
        .SID_WORD(subsystem_ident));

    always #12.5 MCLK = ~MCLK;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge MCLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Image and ROM register images as the size code should leave them
    function automatic logic [31:0] imgx(logic [15:0] b, logic [3:0] c, logic p, logic s);
        return {b & (16'hffff << c), 12'h000, p, 2'b00, s};
    endfunction : imgx

    function automatic logic [31:0] romx(logic [15:0] b, logic [2:0] c, logic e);
        return {b & (16'hffff << c), 15'h0000, e};
    endfunction : romx

    // One access on either port; read data taken at the valid cycle
    task automatic bus(input bit l, input bit w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge MCLK);
        {LCL_WR, LCL_RD, CFG_WR, CFG_RD} <= {l & w, l & !w, !l & w, !l & !w};
        {LCL_ADDR, CFG_ADDR, LCL_WDATA, CFG_WDATA} <= {a, a, wd, wd};
        @(posedge MCLK);
        {LCL_WR, LCL_RD, CFG_WR, CFG_RD} <= 4'h0;
        #1 rd = l ? LCL_RDATA : CFG_RDATA;
    endtask : bus

    task automatic rdc(input bit l, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(l, 0, a, 32'h0, d);
        chk(d, e);
    endtask : rdc

    // Address phase, hits looked at in the cycle after
    task automatic dec(input logic [31:0] a, input logic io, input logic [2:0] e);
        @(posedge MCLK);
        {ADDR_PHASE, AD, ADDR_IS_IO} <= {1'b1, a, io};
        @(posedge MCLK);
        ADDR_PHASE <= 1'b0;
        #1 chk({29'h0, IMG0_HIT, IMG1_HIT, ROM_HIT}, {29'h0, e});
    endtask : dec

    // Straps settle with reset held; waits for any EEPROM load to end
    task automatic boot(input logic pin, input logic dis, input logic [7:0] r5, i7, i8);
        int n;
        ARST_N <= 1'b0;
        subsystem_ident = $urandom;
        {EEPROM_ENABLE_PIN, PCI_DISABLE_OPTION, b5, b7, b8, slow} <= {pin, dis, r5, i7, i8, subsystem_ident[0]};
        repeat (2) @(posedge MCLK);
        ARST_N <= 1'b1;
        for (n = 0; n < 40 && !(n > 10 && EE_LOAD_REQ === 1'b0); n++)
            @(posedge MCLK);
    endtask : boot

    initial
    begin
        logic [31:0] d, a;
        int c;
        void'($urandom(14));
        // Nothing strapped: image 0 and ROM registers zero and closed to writes, identifier zero
        boot(0, 0, 8'hff, 8'hff, 8'hff);
        bus(0, 1, OFS_IMG0, 32'hffffffff, d);
        bus(1, 1, OFS_ROM, 32'hffffffff, d);
        rdc(0, OFS_IMG0, 32'h0);
        rdc(1, OFS_ROM, 32'h0);
        rdc(0, OFS_SID, 32'h0);
        $display("Test strapped off done");
        // Disable option alone opens image 1
        boot(0, 1, 8'h00, 8'h00, 8'h00);
        bus(0, 1, OFS_IMG1, 32'hffffffff, d);
        rdc(0, OFS_IMG1, 32'hffff0000);
        $display("Test disable option done");
        // Loaded: image 0 prefetchable memory, image 1 I/O, ROM on
        boot(1, 0, 8'h80, 8'h60, 8'ha0);
        rdc(1, OFS_SID, subsystem_ident);
        rdc(0, OFS_IMG0, 32'h8);
        rdc(0, OFS_IMG1, 32'h1);
        bus(0, 1, OFS_SID, ~subsystem_ident, d);
        rdc(0, OFS_SID, subsystem_ident);
        bus(1, 1, OFS_SID, ~subsystem_ident, d);
        rdc(0, OFS_SID, ~subsystem_ident);
        // Sizing and decode for every image size code
        for (c = 0; c < 16; c++)
        begin
            IMG0_BLOCK_SIZE_CODE <= c[3:0];
            bus(0, 1, OFS_IMG0, 32'hffffffff, d);
            rdc(0, OFS_IMG0, imgx(16'hffff, c[3:0], 1'b1, 1'b0));
            a = $urandom;
            bus(0, 1, OFS_IMG0, a, d);
            dec(a, 1'b0, 3'b100);
            dec(a ^ (32'h10000 << c), 1'b0, 3'b000);
        end
        dec(a, 1'b1, 3'b000);
        // Image 1 at 2 Gbytes: an I/O cycle below the top line hits a zero base
        IMG1_BLOCK_SIZE_CODE <= 4'hf;
        dec({1'b0, a[30:0]}, 1'b1, 3'b010);
        // Prefetch needs both the flag and the control enable
        IMG0_LOCAL_PREFETCH_ENABLE <= 1'b1;
        bus(0, 1, OFS_IMG0, 32'h0, d);
        chk({31'h0, IMG0_PREFETCH_ACTIVE}, 32'h1);
        bus(1, 1, OFS_IMG0, 32'h0, d);
        // The prefetch output lags the flag by one register stage
        @(posedge MCLK);
        #1 chk({31'h0, IMG0_PREFETCH_ACTIVE}, 32'h0);
        $display("Test image sizing done");
        // Messaging unit moves image 0 down
        MESSAGING_UNIT_ENABLE <= 1'b1;
        bus(1, 1, OFS_IMG0_ALT, 32'hffffffff, d);
        rdc(0, OFS_IMG0_ALT, 32'h80000008);
        rdc(0, OFS_IMG0, 32'h0);
        MESSAGING_UNIT_ENABLE <= 1'b0;
        // ROM sizes from both buses; image 0 still decodes AD31 against 1
        for (c = 0; c < 8; c++)
        begin
            ROM_BLOCK_SIZE_CODE <= c[2:0];
            bus(c[0], 1, OFS_ROM, 32'hffffffff, d);
            rdc(0, OFS_ROM, romx(16'hffff, c[2:0], 1'b1));
            a = $urandom | 32'h1;
            bus(1, 1, OFS_ROM, a, d);
            dec(a, 1'b0, {a[31], 2'b01});
        end
        bus(0, 1, OFS_ROM, a & ~32'h1, d);
        dec(a, 1'b0, {a[31], 2'b00});
        $display("Test ROM done");
        // Second reset clears bases; image 1 and ROM left off
        boot(1, 0, 8'h00, 8'h60, 8'h00);
        rdc(0, OFS_IMG0, 32'h8);
        bus(0, 1, OFS_IMG1, 32'hffffffff, d);
        rdc(0, OFS_IMG1, 32'h0);
        rdc(1, OFS_ROM, 32'h0);
        $display("Test second reset done");
        tally_and_finish();
    end
endmodule : tb_pci_target_bar_config
